// ==== design/xfc_pkg.sv ====
// package for the extension feature control register block
package xfc_pkg;
	localparam logic [11:0] XFC_CTRL_LO_OFF   = 12'h000;
	localparam logic [11:0] XFC_CTRL_HI_OFF   = 12'h004;
	localparam logic [11:0] XFC_INT_STAT_OFF  = 12'h008;
	localparam logic [11:0] XFC_INT_MASK_OFF  = 12'h00c;
	localparam logic [11:0] XFC_CORE_STAT_OFF = 12'h010;

	localparam int XFC_VME_BIT    = 0;
	localparam int XFC_PVI_BIT    = 1;
	localparam int XFC_TSD_BIT    = 2;
	localparam int XFC_DBG_BIT    = 3;
	localparam int XFC_PSE_BIT    = 4;
	localparam int XFC_PAE_BIT    = 5;
	localparam int XFC_MCE_BIT    = 6;
	localparam int XFC_PGE_BIT    = 7;
	localparam int XFC_PCE_BIT    = 8;
	localparam int XFC_FSR_BIT    = 9;
	localparam int XFC_SIMD_BIT   = 10;
	localparam int XFC_SEGB_BIT   = 16;
	localparam int XFC_XSAVE_BIT  = 18;
	localparam int XFC_EXEC_BIT   = 20;
	localparam int XFC_ACC_BIT    = 21;

	localparam logic [63:0] XFC_WRITABLE_MASK = 64'h0000_0000_0035_07ff;
	localparam logic [63:0] XFC_CTRL_RESET    = 64'h0000_0000_0000_0000;

	// interrupt status bit positions
	localparam int XFC_EV_RSVD_GP  = 0;
	localparam int XFC_EV_MC_EXC   = 1;
	localparam int XFC_EV_UD_DBG   = 2;
	localparam int XFC_EV_PRIV_VIO = 3;
	localparam int XFC_EV_W        = 4;
	localparam logic [3:0] XFC_EV_RESET = 4'h0;

	typedef struct packed {
		logic [63:0]          ctrl;
		logic [XFC_EV_W-1:0]  int_stat;
		logic [XFC_EV_W-1:0]  int_mask;
		logic [31:0]          prdata;
	} xfc_state_t;

	typedef struct packed {
		logic       psel;
		logic       penable;
		logic       pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} xfc_apb_req_t;

	typedef struct packed {
		logic       long_mode;
		logic [1:0] current_privilege_level;
		logic       tsc_read;
		logic       pmc_read;
		logic [2:0] dbg_reg_sel;
		logic       dbg_access;
		logic       dir_page_size;
		logic       leaf_global;
		logic       uncorr_err;
		logic       corr_err;
	} xfc_core_in_t;

	typedef struct packed {
		logic       vif_virtualize;
		logic       redirect_bitmap_en;
		logic       sti_cli_virtual;
		logic       tsc_allowed;
		logic       pmc_allowed;
		logic       io_breakpoint_en;
		logic       dbg_ud;
		logic [2:0] dbg_reg_eff;
		logic       large_page;
		logic       page_2m;
		logic       entry_64bit;
		logic       keep_on_base_write;
		logic       mc_exception;
		logic       mc_record;
		logic       gp_fault;
		logic [21:0] feature_en;
	} xfc_core_out_t;
endpackage

// ==== design/xfc_ctrl.sv ====
// extension feature control register with apb access and feature decode
// Notes on behaviour
// RL1: outside long mode only the low 32 bits are visible, same as low word.
// RL2: bits 21,20,18,16,10,9 hold access, exec, xsave, segbase, simd, fast-save enables.
// RL3: bits 0 to 8 hold vm86, pvi, tsd, debug, pse, pae, mce, pge, pce enables.
// RL4: vm86 extension virtualizes interrupt flag and enables redirection bitmap intercept.
// RL5: pvi enables virtual flags for set/clear interrupt only, no bitmap.
// RL6: timestamp reads allowed at any level unless disable bit set, then level 0.
// RL7: debug extension on enables io breakpoints, debug regs four/five fault.
// RL8: debug extension off disables io breakpoints, aliases four/five to six/seven.
// RL9: page-size extension selects 4K or 4M by directory flag, else 4K.
// RL10: page-size extension ignored while physical-address extension set.
// RL11: physical-address extension gives 64-bit entries, 52-bit addresses, 4K/2M pages.
// RL12: software enables physical-address extension before entering long mode.
// RL13: machine-check enable gates exceptions on uncorrectable errors.
// RL14: errors are recorded whatever the machine-check enable holds.
// RL15: global page enable keeps global translations on table base rewrite.
// RL16: counter reads allowed at any level when enabled, else level 0.
// RL17: software checks feature identification before enabling a bit, except counter read.
// RL18: reserved bits read zero; nonzero write to them raises protection fault.
// RL19: all enables reset to zero.
module xfc_ctrl
	import xfc_pkg::*;
(
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// core side
	input  wire xfc_pkg::xfc_core_in_t core_in,
	output xfc_pkg::xfc_core_out_t     core_out,
	// interrupt
	output logic                       irq
);
	import xfc_pkg::*;

	xfc_state_t state_reg;
	xfc_state_t state_next;

	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit_lo;
	logic        hit_hi;
	logic        hit_is;
	logic        hit_im;
	logic        hit_cs;
	logic        mapped;
	logic [31:0] strb_mask;
	logic [31:0] wdata_m;
	logic [63:0] ctrl_wr;
	logic [63:0] rsvd_hits;
	logic        rsvd_err;
	logic        hi_blocked;
	logic [XFC_EV_W-1:0] ev;
	logic [63:0] c;

	// zero-wait slave: every access completes in its first access cycle
	assign acc    = psel & penable;
	assign wr     = acc & pwrite;
	assign rd     = acc & ~pwrite;
	assign hit_lo = (paddr == XFC_CTRL_LO_OFF);
	assign hit_hi = (paddr == XFC_CTRL_HI_OFF);
	assign hit_is = (paddr == XFC_INT_STAT_OFF);
	assign hit_im = (paddr == XFC_INT_MASK_OFF);
	assign hit_cs = (paddr == XFC_CORE_STAT_OFF);
	assign mapped = hit_lo | hit_hi | hit_is | hit_im | hit_cs;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_strb
			assign strb_mask[gi*8 +: 8] = {8{pstrb[gi]}};
		end
	endgenerate

	assign wdata_m = pwdata & strb_mask;
	assign c       = state_reg.ctrl;

	// merged write image of the full control word
	always_comb begin
		ctrl_wr = c;
		if (hit_lo) begin
			ctrl_wr[31:0] = (c[31:0] & ~strb_mask) | wdata_m;
		end
		if (hit_hi) begin
			ctrl_wr[63:32] = (c[63:32] & ~strb_mask) | wdata_m;
		end
	end

	// high word exists only in long mode
	assign hi_blocked = hit_hi & ~core_in.long_mode; // RL1
	assign rsvd_hits  = ctrl_wr & ~XFC_WRITABLE_MASK; // RL18
	assign rsvd_err   = wr & (hit_lo | hit_hi) & ~hi_blocked & (|rsvd_hits); // RL18

	assign pready  = 1'b1;
	assign pslverr = acc & (~mapped | hi_blocked | rsvd_err);

	// feature decode
	always_comb begin
		core_out = '0;
		core_out.vif_virtualize     = c[XFC_VME_BIT] | c[XFC_PVI_BIT]; // RL4 RL5
		core_out.redirect_bitmap_en = c[XFC_VME_BIT]; // RL4
		core_out.sti_cli_virtual    = c[XFC_PVI_BIT] & ~c[XFC_VME_BIT]; // RL5
		core_out.tsc_allowed        = ~c[XFC_TSD_BIT] | (core_in.current_privilege_level == 2'd0); // RL6
		core_out.pmc_allowed        = c[XFC_PCE_BIT] | (core_in.current_privilege_level == 2'd0); // RL16
		core_out.io_breakpoint_en   = c[XFC_DBG_BIT]; // RL7 RL8
		core_out.dbg_ud             = c[XFC_DBG_BIT] & core_in.dbg_access
			& (core_in.dbg_reg_sel == 3'd4 | core_in.dbg_reg_sel == 3'd5); // RL7
		core_out.dbg_reg_eff        = core_in.dbg_reg_sel;
		if (!c[XFC_DBG_BIT] && (core_in.dbg_reg_sel == 3'd4 || core_in.dbg_reg_sel == 3'd5)) begin
			core_out.dbg_reg_eff = core_in.dbg_reg_sel + 3'd2; // RL8
		end
		core_out.entry_64bit        = c[XFC_PAE_BIT]; // RL11
		core_out.page_2m            = c[XFC_PAE_BIT] & core_in.dir_page_size; // RL11
		core_out.large_page         = c[XFC_PSE_BIT] & ~c[XFC_PAE_BIT] & ~core_in.long_mode
			& core_in.dir_page_size; // RL9 RL10
		core_out.keep_on_base_write = c[XFC_PGE_BIT] & core_in.leaf_global; // RL15
		core_out.mc_exception       = c[XFC_MCE_BIT] & core_in.uncorr_err; // RL13
		core_out.mc_record          = core_in.uncorr_err | core_in.corr_err; // RL14
		core_out.gp_fault           = rsvd_err; // RL18
		core_out.feature_en         = c[21:0];
	end

	// events latched for software
	always_comb begin
		ev = '0;
		ev[XFC_EV_RSVD_GP]  = rsvd_err;
		ev[XFC_EV_MC_EXC]   = core_out.mc_exception;
		ev[XFC_EV_UD_DBG]   = core_out.dbg_ud;
		ev[XFC_EV_PRIV_VIO] = (core_in.tsc_read & ~core_out.tsc_allowed)
			| (core_in.pmc_read & ~core_out.pmc_allowed);
	end

	always_comb begin
		state_next = state_reg;
		if (wr && (hit_lo || hit_hi) && !hi_blocked && !rsvd_err) begin
			state_next.ctrl = ctrl_wr & XFC_WRITABLE_MASK; // RL2 RL3
		end
		if (wr && hit_im) begin
			state_next.int_mask = (state_reg.int_mask & ~strb_mask[XFC_EV_W-1:0])
				| wdata_m[XFC_EV_W-1:0];
		end
		// set wins over a same-cycle clear
		if (wr && hit_is) begin
			state_next.int_stat = state_reg.int_stat & ~wdata_m[XFC_EV_W-1:0];
		end
		state_next.int_stat = state_next.int_stat | ev;
		state_next.prdata = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			if (paddr == XFC_CTRL_LO_OFF) begin
				state_next.prdata = c[31:0]; // RL1
			end else if (paddr == XFC_CTRL_HI_OFF && core_in.long_mode) begin
				state_next.prdata = c[63:32]; // RL18
			end else if (paddr == XFC_INT_STAT_OFF) begin
				state_next.prdata = {28'h0000000, state_reg.int_stat};
			end else if (paddr == XFC_INT_MASK_OFF) begin
				state_next.prdata = {28'h0000000, state_reg.int_mask};
			end else if (paddr == XFC_CORE_STAT_OFF) begin
				state_next.prdata = {29'h00000000, core_in.long_mode, core_in.current_privilege_level};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.ctrl     <= XFC_CTRL_RESET; // RL19
			state_reg.int_stat <= XFC_EV_RESET;
			state_reg.int_mask <= XFC_EV_RESET;
			state_reg.prdata   <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata = rd ? state_reg.prdata : 32'h0000_0000;
	assign irq    = |(state_reg.int_stat & state_reg.int_mask);
endmodule // xfc_ctrl

// ==== bench/xfc_monitor.sv ====
// port assertions for the extension control block
module xfc_monitor
	import xfc_pkg::*;
(
	// clock, reset and apb
	input wire logic                  pclk,
	input wire logic                  presetn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	// core side
	input wire xfc_pkg::xfc_core_in_t  core_in,
	input wire xfc_pkg::xfc_core_out_t core_out
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire        lo_acc = psel && penable && paddr == XFC_CTRL_LO_OFF;
	wire [21:0] f      = core_out.feature_en;
	wire        hi_sel = core_in.dbg_reg_sel[2:1] == 2'b10;
	tsc_gate_a: assert property (core_out.tsc_allowed == (!f[2] || core_in.current_privilege_level == 2'h0))
		else $error("timestamp gate wrong");
	pmc_gate_a: assert property (core_out.pmc_allowed == (f[8] || core_in.current_privilege_level == 2'h0))
		else $error("counter gate wrong");
	dbg_fault_a: assert property (f[3] && core_in.dbg_access && hi_sel |-> core_out.dbg_ud)
		else $error("debug fault missing");
	dbg_alias_a: assert property (!f[3] && hi_sel |-> core_out.dbg_reg_eff == {2'b11, core_in.dbg_reg_sel[0]})
		else $error("debug alias wrong");
	big_page_a: assert property (core_out.large_page == (f[4] && !f[5] && !core_in.long_mode && core_in.dir_page_size))
		else $error("page size wrong");
	mc_exc_a: assert property (core_out.mc_exception == (f[6] && core_in.uncorr_err))
		else $error("machine check wrong");
	low_view_a: assert property (lo_acc && !pwrite |-> prdata == {10'h000, f})
		else $error("low word view wrong");
	rsvd_write_a: assert property (lo_acc && pwrite && |(pwdata & ~XFC_WRITABLE_MASK[31:0]) |-> pslverr ##1 $stable(f))
		else $error("reserved write kept");
	reset_clear_a: assert property ($rose(presetn) |-> f == 22'h000000)
		else $error("enables not cleared");
	cover property (lo_acc && pslverr);
	cover property (core_out.dbg_ud);
	cover property (core_out.large_page);
endmodule // xfc_monitor

// ==== bench/testbench.sv ====
// self-checking bench for the extension control block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import xfc_pkg::*;
	logic          pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0, prdata, rd;
	logic [3:0]    pstrb = 4'hf;
	logic          pready, pslverr, irq, err;
	xfc_core_in_t  core_in = '0;
	xfc_core_out_t core_out;
	logic [63:0]   m = 64'h0;
	int            fail_count = 0, n_checks = 0, cyc = 0;
	always #5 pclk = ~pclk;
	xfc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_in(core_in), .core_out(core_out), .irq(irq));
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("Error at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// random core requests, decode compared with the model
	task automatic dec();
		logic [2:0] s;
		@(posedge pclk);
		core_in <= xfc_core_in_t'({core_in.long_mode, 12'($urandom)});
		@(negedge pclk);
		s = core_in.dbg_reg_sel;
		chk(core_out.tsc_allowed, !m[2] || core_in.current_privilege_level == 2'h0);
		chk(core_out.pmc_allowed, m[8] || core_in.current_privilege_level == 2'h0);
		chk(core_out.redirect_bitmap_en, m[0]);
		chk(core_out.io_breakpoint_en, m[3]);
		chk(core_out.dbg_reg_eff, (!m[3] && s[2:1] == 2'b10) ? {2'b11, s[0]} : s);
		chk(core_out.large_page, m[4] && !m[5] && !core_in.long_mode && core_in.dir_page_size);
		chk(core_out.vif_virtualize, m[0] || m[1]);
		chk(core_out.sti_cli_virtual, m[1] && !m[0]);
		chk(core_out.dbg_ud, m[3] && core_in.dbg_access && s[2:1] == 2'b10);
		chk(core_out.page_2m, m[5] && core_in.dir_page_size);
		chk(core_out.keep_on_base_write, m[7] && core_in.leaf_global);
		chk(core_out.mc_record, core_in.uncorr_err || core_in.corr_err);
		chk(core_out.entry_64bit, m[5]);
		chk(core_out.mc_exception, m[6] && core_in.uncorr_err);
		chk(core_out.feature_en, m[21:0]);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(32'hc9a41f10));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, XFC_CTRL_LO_OFF, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 12; i++) begin
			m[31:0] = (i == 0 ? 32'hffffffff : $urandom) & XFC_WRITABLE_MASK[31:0];
			apb(1'b1, XFC_CTRL_LO_OFF, m[31:0]);
			apb(1'b0, XFC_CTRL_LO_OFF, 32'h0);
			chk(rd, m[31:0]);
			dec();
		end
		apb(1'b1, XFC_INT_STAT_OFF, 32'hf);
		// every reserved bit of the low word refused on its own, stored word untouched
		for (int b = 11; b < 32; b++) if (!XFC_WRITABLE_MASK[b]) begin
			apb(1'b1, XFC_CTRL_LO_OFF, m[31:0] ^ (32'h1 << b));
			chk(err, 1'b1);
		end
		apb(1'b0, XFC_CTRL_LO_OFF, 32'h0);
		chk(rd, m[31:0]);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, XFC_INT_MASK_OFF, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b1);
		apb(1'b0, XFC_INT_STAT_OFF, 32'h0);
		chk(rd[0], 1'b1);
		apb(1'b1, XFC_INT_STAT_OFF, 32'h1);
		repeat (2) @(negedge pclk);
		chk(irq, 1'b0);
		apb(1'b1, XFC_CTRL_HI_OFF, 32'h0);
		chk(err, 1'b1);
		// long mode only ever entered with the address extension on
		m[31:0] = m[31:0] | (32'h1 << XFC_PAE_BIT) | (32'h1 << XFC_PCE_BIT);
		apb(1'b1, XFC_CTRL_LO_OFF, m[31:0]);
		chk(err, 1'b0);
		@(posedge pclk);
		core_in.long_mode <= 1'b1;
		dec();
		apb(1'b1, XFC_CTRL_HI_OFF, 32'h1);
		chk(err, 1'b1);
		apb(1'b0, XFC_CTRL_HI_OFF, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk(err, 1'b1);
		wrap_up();
	end
endmodule // testbench
bind xfc_ctrl xfc_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
	.core_in(core_in), .core_out(core_out));
